// >>> rtl/tcd_addr_gen.v
// address generator: byte or word addressing for one side of a transfer
`timescale 1ns/1ps
`default_nettype none
module tcd_addr_gen (
  input  wire [15:0] base,
  input  wire [7:0]  count,
  input  wire [1:0]  mode,
  input  wire        word_mode,
  input  wire        is_dst,
  output reg  [15:0] addr
);
  // mode: 2=increment 1=decrement 0=static
  always @* begin
    case (mode)
      2'h2:    addr = base + {8'h00, count};
      2'h1:    addr = base - {8'h00, count};
      default: addr = (word_mode && count[0]) ? base + 16'h0001 : base;
    endcase
    // decremented destination still steps down by count on odd bytes in word mode
    if (is_dst && word_mode && mode == 2'h1 && count[0])
      addr = base - {8'h00, count};
  end
endmodule // tcd_addr_gen
`default_nettype wire

// >>> rtl/tcd_bw_pacer.v
// bandwidth pacer: interleaves engine and cpu bus cycles
`timescale 1ns/1ps
`default_nettype none
module tcd_bw_pacer (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [1:0] bw_sel,
  input  wire       active,
  input  wire       force_gap,
  output reg        grant
);
  reg [2:0] phase_q;
  reg [2:0] len;
  // period length: 2 engine cycles then 6, 2, 1 or none for cpu
  always @* begin
    case (bw_sel)
      2'h0:    len = 3'h7;
      2'h1:    len = 3'h3;
      2'h2:    len = 3'h2;
      default: len = 3'h0;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
    end else if (!active || force_gap || phase_q == len) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end
  always @* begin
    grant = active && !force_gap && (bw_sel == 2'h3 || phase_q < 3'h2);
  end
endmodule // tcd_bw_pacer
`default_nettype wire

// >>> rtl/tcd_defines.vh
// register offsets, field positions, reset values and timing counts of the three-channel engine
`ifndef TCD_DEFINES_VH
`define TCD_DEFINES_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCD_OFF_CTL1     6'h00
`define TCD_OFF_STAT     6'h01
`define TCD_OFF_CTL2     6'h02
`define TCD_OFF_BRK      6'h03
`define TCD_OFF_BRKADR_H 6'h04
`define TCD_OFF_BRKADR_L 6'h05
`define TCD_OFF_CH_BASE  6'h08
`define TCD_CH_STRIDE    6'h08
`define TCD_CH_SRC_H     3'h0
`define TCD_CH_SRC_L     3'h1
`define TCD_CH_DST_H     3'h2
`define TCD_CH_DST_L     3'h3
`define TCD_CH_CTL       3'h4
`define TCD_CH_CNT       3'h5
`define TCD_CH_LEN       3'h6
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCD_C1_BWLO 0
`define TCD_C1_BWHI 1
`define TCD_C1_TEC  2
`define TCD_C1_IEC  5
`define TCD_ST_IFC  0
`define TCD_ST_WRE  3
`define TCD_ST_LOOP 4
`define TCD_ST_PRI  7
`define TCD_BK_BREAK_CLEAR_ENABLE 7
`define TCD_CC_BWS  3
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define TCD_CTL1_RST  8'h00
`define TCD_STAT_RST  8'h00
`define TCD_BRK_RST   8'h00
`define TCD_LAT_DIS   2'h2
`define TCD_LAT_EN    2'h3
`endif

// >>> rtl/tcd_engine.v
// three-channel transfer engine: registers, arbitration, sequencing, low-power and break handling
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcd_defines.vh"
module tcd_engine (
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire [5:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  input  wire [2:0]  CH_REQ,
  input  wire        WAIT_MODE,
  input  wire        STOP_MODE,
  input  wire        STOP_RESET_EXIT,
  input  wire        BREAK_ACT,
  input  wire        CPU_IRQ,
  output reg         BUS_OWN,
  output reg  [15:0] BUS_ADDR,
  output reg         BUS_WRITE,
  output reg  [2:0]  IRQ_REQ,
  output reg         BREAK_HIT
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]  ctl1_q, stat_q, ctl2_q, brk_q;
  reg  [15:0] brk_addr_q;
  reg  [15:0] src_q [0:2];
  reg  [15:0] dst_q [0:2];
  reg  [7:0]  cctl_q [0:2];
  reg  [7:0]  cnt_q [0:2];
  reg  [7:0]  len_q [0:2];
  reg  [2:0]  armed_q;   // first clearing step (read) done
  reg         busy_q;
  reg  [1:0]  ch_q;
  reg         phase_q;   // 0 read source, 1 write destination
  reg         susp_q;
  reg  [1:0]  lat_q;
  reg         gap_q;
  reg         stop_seen_q;
  integer     i;

  wire [5:0] ch_off = ADDR - `TCD_OFF_CH_BASE;
  wire [1:0] wr_ch = ch_off[4:3];
  // upper addresses must not alias onto the channel windows
  wire       ch_acc = (ADDR >= `TCD_OFF_CH_BASE) && !ch_off[5] && (wr_ch != 2'h3);
  wire       in_brk = BREAK_ACT;
  wire       break_clear_enable = brk_q[`TCD_BK_BREAK_CLEAR_ENABLE];
  wire       pri = stat_q[`TCD_ST_PRI];
  wire [2:0] tec = ctl1_q[`TCD_C1_TEC+2:`TCD_C1_TEC];
  wire [2:0] iec = ctl1_q[`TCD_C1_IEC+2:`TCD_C1_IEC];

  // ----------------------------------------------------------------
  // per-channel address generation
  // ----------------------------------------------------------------
  wire [15:0] src_a [0:2];
  wire [15:0] dst_a [0:2];
  wire [2:0]  wmode;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gch
      // word only with a static side
      assign wmode[g] = cctl_q[g][`TCD_CC_BWS] &&
                        (cctl_q[g][7:6] == 2'h0 || cctl_q[g][5:4] == 2'h0);
      tcd_addr_gen u_src (
        .base      (src_q[g]),
        .count     (cnt_q[g]),
        .mode      (cctl_q[g][7:6]),
        .word_mode (wmode[g]),
        .is_dst    (1'b0),
        .addr      (src_a[g])
      );
      tcd_addr_gen u_dst (
        .base      (dst_q[g]),
        .count     (cnt_q[g]),
        .mode      (cctl_q[g][5:4]),
        .word_mode (wmode[g]),
        .is_dst    (1'b1),
        .addr      (dst_a[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration and pacing
  // ----------------------------------------------------------------
  wire [2:0] pend = tec & (CH_REQ | ctl2_q[2:0]);
  reg  [1:0] pick;
  always @* begin
    pick = pend[0] ? 2'h0 : (pend[1] ? 2'h1 : 2'h2);
  end
  // engine held off in stop or non-run wait
  wire hold = STOP_MODE || (WAIT_MODE && !stat_q[`TCD_ST_WRE]);
  wire grant;
  tcd_bw_pacer u_pace (
    .clk       (MCLK),
    .rst_n     (ARST_N),
    .bw_sel    (ctl1_q[`TCD_C1_BWHI:`TCD_C1_BWLO]),
    .active    (busy_q || pend != 3'h0),
    .force_gap (gap_q),
    .grant     (grant)
  );
  // no bus while break; latency stall
  wire go = grant && !hold && !in_brk && lat_q == 2'h0;
  wire [15:0] cur_a = phase_q ? dst_a[ch_q] : src_a[ch_q];
  wire last = (cnt_q[ch_q] + 8'h01) == len_q[ch_q];
  // cpu interrupt with priority clear preempts
  wire preempt = CPU_IRQ && !pri;

  // ----------------------------------------------------------------
  // sequencer and register writes
  // ----------------------------------------------------------------
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl1_q <= `TCD_CTL1_RST;
      stat_q <= `TCD_STAT_RST;
      ctl2_q <= 8'h00;
      brk_q <= `TCD_BRK_RST;
      brk_addr_q <= 16'h0000;
      for (i = 0; i < 3; i = i + 1) begin
        src_q[i] <= 16'h0000;
        dst_q[i] <= 16'h0000;
        cctl_q[i] <= 8'h00;
        cnt_q[i] <= 8'h00;
        len_q[i] <= 8'h00;
      end
      armed_q <= 3'h0;
      busy_q <= 1'b0;
      ch_q <= 2'h0;
      phase_q <= 1'b0;
      susp_q <= 1'b0;
      lat_q <= 2'h0;
      gap_q <= 1'b0;
      stop_seen_q <= 1'b0;
      BUS_OWN <= 1'b0;
      BUS_ADDR <= 16'h0000;
      BUS_WRITE <= 1'b0;
      IRQ_REQ <= 3'h0;
      BREAK_HIT <= 1'b0;
    end else begin
      gap_q <= 1'b0;
      if (lat_q != 2'h0)
        lat_q <= lat_q - 2'h1;
      if (WR) begin
        case (ADDR)
          `TCD_OFF_CTL1:     ctl1_q <= WDATA;
          `TCD_OFF_CTL2:     ctl2_q <= WDATA;
          `TCD_OFF_BRK:      brk_q <= WDATA;
          `TCD_OFF_BRKADR_H: brk_addr_q[15:8] <= WDATA;
          `TCD_OFF_BRKADR_L: brk_addr_q[7:0] <= WDATA;
          `TCD_OFF_STAT:     stat_q[7:3] <= WDATA[7:3];
          default: ;
        endcase
        if (ch_acc) begin
          case (ch_off[2:0])
            `TCD_CH_SRC_H: src_q[wr_ch][15:8] <= WDATA;
            `TCD_CH_SRC_L: src_q[wr_ch][7:0] <= WDATA;
            `TCD_CH_DST_H: dst_q[wr_ch][15:8] <= WDATA;
            `TCD_CH_DST_L: dst_q[wr_ch][7:0] <= WDATA;
            `TCD_CH_CTL:   cctl_q[wr_ch] <= WDATA;
            `TCD_CH_CNT:   cnt_q[wr_ch] <= WDATA;
            `TCD_CH_LEN:   len_q[wr_ch] <= WDATA;
            default: ;
          endcase
          if (ch_off[2:0] == `TCD_CH_CTL && busy_q)
            lat_q <= tec[wr_ch] ? `TCD_LAT_EN : `TCD_LAT_DIS;
        end
      end
      // two-step flag clear, protected in break unless enabled
      if (RD && ADDR == `TCD_OFF_STAT && (!in_brk || break_clear_enable))
        armed_q <= stat_q[2:0];
      if (WR && ADDR == `TCD_OFF_STAT && (!in_brk || break_clear_enable)) begin
        stat_q[2:0] <= stat_q[2:0] & ~(armed_q & ~WDATA[2:0]);
        armed_q <= 3'h0;
      end
      // stop exit by reset aborts, else resume if priority set
      stop_seen_q <= STOP_MODE;
      if (stop_seen_q && !STOP_MODE && busy_q) begin
        if (STOP_RESET_EXIT || !pri)
          busy_q <= 1'b0;
      end
      // wait exit without priority select drops the suspended transfer
      if (WAIT_MODE && !stat_q[`TCD_ST_WRE])
        susp_q <= busy_q;
      else if (susp_q) begin
        susp_q <= 1'b0;
        if (!pri)
          busy_q <= 1'b0;
      end
      // break hit drops once break is over; a new match below wins
      if (!in_brk)
        BREAK_HIT <= 1'b0;
      BUS_OWN <= 1'b0;
      BUS_WRITE <= 1'b0;
      if (preempt && !busy_q) begin
        ctl1_q[`TCD_C1_TEC+2:`TCD_C1_TEC] <= 3'h0;
      end else if (!busy_q && pend != 3'h0 && go) begin
        // one channel at a time; source cycle issued at start
        busy_q <= 1'b1;
        ch_q <= pick;
        phase_q <= 1'b1;
        BUS_OWN <= 1'b1;
        BUS_ADDR <= src_a[pick];
        BUS_WRITE <= 1'b0;
        if (src_a[pick] == brk_addr_q)
          BREAK_HIT <= 1'b1;
      end else if (busy_q && go) begin
        BUS_OWN <= 1'b1;
        BUS_ADDR <= cur_a;
        BUS_WRITE <= phase_q;
        if (cur_a == brk_addr_q)
          BREAK_HIT <= 1'b1;
        phase_q <= ~phase_q;
        if (phase_q) begin
          busy_q <= 1'b0;
          if (last) begin
            // done flag, set wins over clear
            stat_q[`TCD_ST_IFC + ch_q] <= 1'b1;
            cnt_q[ch_q] <= 8'h00;
            if (!stat_q[`TCD_ST_LOOP + ch_q])
              ctl1_q[`TCD_C1_TEC + ch_q] <= 1'b0;
            ctl2_q[ch_q] <= 1'b0;
            gap_q <= 1'b1;
          end else begin
            cnt_q[ch_q] <= cnt_q[ch_q] + 8'h01;
            if (preempt)
              ctl1_q[`TCD_C1_TEC+2:`TCD_C1_TEC] <= 3'h0;
          end
        end
      end
      IRQ_REQ <= stat_q[2:0] & iec;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= 8'h00;
      case (ADDR)
        `TCD_OFF_CTL1:     RDATA <= ctl1_q;
        `TCD_OFF_STAT:     RDATA <= stat_q;
        `TCD_OFF_CTL2:     RDATA <= ctl2_q;
        `TCD_OFF_BRK:      RDATA <= brk_q;
        `TCD_OFF_BRKADR_H: RDATA <= brk_addr_q[15:8];
        `TCD_OFF_BRKADR_L: RDATA <= brk_addr_q[7:0];
        default: ;
      endcase
      if (ch_acc) begin
        case (ch_off[2:0])
          `TCD_CH_SRC_H: RDATA <= src_q[wr_ch][15:8];
          `TCD_CH_SRC_L: RDATA <= src_q[wr_ch][7:0];
          `TCD_CH_DST_H: RDATA <= dst_q[wr_ch][15:8];
          `TCD_CH_DST_L: RDATA <= dst_q[wr_ch][7:0];
          `TCD_CH_CTL:   RDATA <= cctl_q[wr_ch];
          `TCD_CH_CNT:   RDATA <= cnt_q[wr_ch];
          `TCD_CH_LEN:   RDATA <= len_q[wr_ch];
          default: ;
        endcase
      end
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule // tcd_engine
`default_nettype wire

// >>> testbench/tb_three_channel_dma_control.sv
// self-checking bench for the three-channel transfer engine
`timescale 1ns/1ps
`default_nettype none
`include "tcd_defines.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_three_channel_dma_control;
  logic        mclk, arst_n, wr, rd, wait_mode, stop_mode, stop_rst, break_act;
  logic        cpu_irq, load, hit_seen, bus_own, bus_write, break_hit;
  logic [5:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [2:0]  ch_req, chan, irq_req;
  logic [3:0]  units;
  logic [15:0] bus_addr;
  logic [15:0] sq[$], dq[$];
  int          errors, n_compared;
  tcd_engine dut (.MCLK(mclk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CH_REQ(ch_req), .WAIT_MODE(wait_mode), .STOP_MODE(stop_mode),
    .STOP_RESET_EXIT(stop_rst), .BREAK_ACT(break_act), .CPU_IRQ(cpu_irq), .BUS_OWN(bus_own),
    .BUS_ADDR(bus_addr), .BUS_WRITE(bus_write), .IRQ_REQ(irq_req), .BREAK_HIT(break_hit));
  tcd_periph u_periph (.mclk(mclk), .arst_n(arst_n), .bus_own(bus_own), .bus_write(bus_write),
    .load(load), .chan(chan), .units(units), .ch_req(ch_req));
  // bus cycle log
  always @(posedge mclk) begin
    if (bus_own === 1'b1 && bus_write === 1'b0) sq.push_back(bus_addr);
    if (bus_own === 1'b1 && bus_write === 1'b1) dq.push_back(bus_addr);
    if (break_hit === 1'b1) hit_seen = 1'b1;
  end
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask
  task automatic set_ch(input logic [1:0] c, input logic [15:0] s, input logic [15:0] d,
                        input logic [7:0] ctl, input logic [7:0] len);
    logic [5:0] b;
    b = `TCD_OFF_CH_BASE + {1'b0, c, 3'h0};
    wr_reg(b, s[15:8]);
    wr_reg(b + 6'h1, s[7:0]);
    wr_reg(b + 6'h2, d[15:8]);
    wr_reg(b + 6'h3, d[7:0]);
    wr_reg(b + 6'h4, ctl);
    wr_reg(b + 6'h5, 8'h00);
    wr_reg(b + 6'h6, len);
    sq.delete();
    dq.delete();
  endtask
  task automatic wait_dst(input int n);
    for (int i = 0; i < 300 && dq.size() < n; i++) @(posedge mclk);
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd_reg(`TCD_OFF_CTL1, v);
    `CHK(v, `TCD_CTL1_RST)
    rd_reg(`TCD_OFF_STAT, v);
    `CHK(v, `TCD_STAT_RST)
    rd_reg(`TCD_OFF_BRK, v);
    `CHK(v, `TCD_BRK_RST)
    wr_reg(6'h3F, 8'hA5);
    rd_reg(6'h3F, v);
    `CHK(v, 8'h00)
    wr_reg(`TCD_OFF_BRKADR_H, 8'h30);
    wr_reg(`TCD_OFF_BRKADR_L, 8'h01);
  endtask
  task automatic t_word();
    logic [7:0] v;
    // full bandwidth for a short block
    wr_reg(`TCD_OFF_CTL1, 8'h27);
    set_ch(2'd0, 16'h1234, 16'h2000, 8'h28, 8'h04);
    wr_reg(`TCD_OFF_CTL2, 8'h01);
    wait_dst(4);
    for (int i = 0; i < 4; i++) begin
      `CHK(sq[i], 16'h1234 + 16'(i & 1))
      `CHK(dq[i], 16'h2000 + 16'(i))
    end
    rd_reg(`TCD_OFF_STAT, v);
    `CHK(v[0], 1'b1)
    `CHK(irq_req, 3'h1)
    rd_reg(`TCD_OFF_CTL1, v);
    `CHK(v, 8'h23)
  endtask
  task automatic t_brkflag();
    logic [7:0] v;
    rd_reg(`TCD_OFF_STAT, v);
    break_act <= 1'b1;
    wr_reg(`TCD_OFF_STAT, 8'h00);
    rd_reg(`TCD_OFF_STAT, v);
    `CHK(v[0], 1'b1)
    break_act <= 1'b0;
    wr_reg(`TCD_OFF_STAT, 8'h00);
    rd_reg(`TCD_OFF_STAT, v);
    `CHK(v[0], 1'b0)
    `CHK(irq_req, 3'h0)
  endtask
  task automatic t_wrap();
    logic [7:0] v;
    wr_reg(`TCD_OFF_CTL1, 8'h09);
    set_ch(2'd1, 16'h0001, 16'hFFFE, 8'h68, 8'h03);
    wr_reg(`TCD_OFF_CTL2, 8'h02);
    wait_dst(3);
    for (int i = 0; i < 3; i++) begin
      `CHK(sq[i], 16'h0001 - 16'(i))
      `CHK(dq[i], 16'hFFFE + 16'(i))
    end
    rd_reg(`TCD_OFF_STAT, v);
    `CHK(v[1], 1'b1)
    `CHK(irq_req, 3'h0)
  endtask
  task automatic t_lowpwr();
    int n;
    wr_reg(`TCD_OFF_CTL1, 8'h10);
    set_ch(2'd2, 16'h3000, 16'h0040, 8'h80, 8'h04);
    units <= 4'h4;
    chan  <= 3'h4;
    load  <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    wait_dst(1);
    stop_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    n = sq.size();
    repeat (8) @(posedge mclk);
    `CHK(sq.size(), n)
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    n = sq.size();
    repeat (8) @(posedge mclk);
    `CHK(sq.size(), n)
    wait_mode <= 1'b0;
    for (int i = 0; i < 400 && ch_req !== 3'h0; i++) @(posedge mclk);
    `CHK(ch_req, 3'h0)
    `CHK(hit_seen, 1'b1)
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  initial begin
    {arst_n, wr, rd, wait_mode, stop_mode, stop_rst, break_act, cpu_irq, load} = 9'h000;
    {addr, wdata, chan, units, hit_seen} = 22'h000000;
    errors = 0;
    n_compared = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_word();
    t_brkflag();
    t_wrap();
    t_lowpwr();
    print_verdict();
  end
endmodule // tb_three_channel_dma_control
`default_nettype wire

// >>> testbench/tcd_engine_props.sv
// assertion checker for the three-channel engine ports
`timescale 1ns/1ps
`default_nettype none
`include "tcd_defines.vh"
module tcd_engine_props (
  input wire logic        MCLK,
  input wire logic        ARST_N,
  input wire logic [5:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        WAIT_MODE,
  input wire logic        STOP_MODE,
  input wire logic        BREAK_ACT,
  input wire logic        CPU_IRQ,
  input wire logic        BUS_OWN,
  input wire logic [15:0] BUS_ADDR,
  input wire logic        BUS_WRITE,
  input wire logic [2:0]  IRQ_REQ,
  input wire logic        BREAK_HIT
);
  logic [1:0]  bw_q;
  logic [2:0]  ien_q;
  logic        wre_q;
  logic [15:0] brk_q;
  logic        calm;
  // shadow copies of the control fields written by software
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bw_q  <= 2'h0;
      ien_q <= 3'h0;
      wre_q <= 1'b0;
      brk_q <= 16'h0000;
    end else if (WR) begin
      if (ADDR == `TCD_OFF_CTL1) bw_q <= WDATA[1:0];
      if (ADDR == `TCD_OFF_CTL1) ien_q <= WDATA[7:5];
      if (ADDR == `TCD_OFF_STAT) wre_q <= WDATA[`TCD_ST_WRE];
      if (ADDR == `TCD_OFF_BRKADR_H) brk_q[15:8] <= WDATA;
      if (ADDR == `TCD_OFF_BRKADR_L) brk_q[7:0] <= WDATA;
    end
  end
  // no low-power, break, interrupt or write in this cycle
  assign calm = !WR && !BREAK_ACT && !WAIT_MODE && !STOP_MODE && !CPU_IRQ;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_src;
    BUS_OWN && !BUS_WRITE;
  endsequence
  sequence s_dst;
    BUS_OWN && BUS_WRITE;
  endsequence
  // --------------------------------------------------------------
  // port relations
  // --------------------------------------------------------------
  AST_PAIR_ORDER: assert property ((BUS_OWN && !BUS_WRITE && calm) |=> s_dst)
    else $error("destination cycle did not follow source cycle");
  AST_BW_BURST: assert property (($rose(BUS_OWN) && bw_q != 2'h3 && calm) |-> s_src ##1 s_dst ##1 !BUS_OWN)
    else $error("engine burst is not two bus cycles");
  AST_BW_QUARTER: assert property (($fell(BUS_OWN) && bw_q == 2'h0 && calm) |-> !BUS_OWN [*6])
    else $error("fewer than six cpu cycles at quarter bandwidth");
  AST_BW_HALF: assert property (($fell(BUS_OWN) && bw_q == 2'h1 && calm) |-> !BUS_OWN [*2])
    else $error("fewer than two cpu cycles at half bandwidth");
  AST_STOP_IDLE: assert property (STOP_MODE [*3] |-> !BUS_OWN)
    else $error("engine used the bus in stop mode");
  AST_WAIT_HOLD: assert property ((WAIT_MODE && !wre_q) [*3] |-> !BUS_OWN)
    else $error("engine used the bus in wait mode without wait-run");
  AST_BRK_FREE: assert property (BREAK_ACT [*4] |-> !BUS_OWN)
    else $error("engine kept the bus during break");
  AST_BRK_HIT: assert property ((BUS_OWN && BUS_ADDR == brk_q) |-> ##[0:2] BREAK_HIT)
    else $error("break address match not reported");
  AST_IRQ_GATE: assert property ((IRQ_REQ & ~(ien_q | $past(ien_q))) == 3'h0)
    else $error("interrupt request from a disabled channel");
endmodule // tcd_engine_props
bind tcd_engine tcd_engine_props u_props (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE),
  .BREAK_ACT(BREAK_ACT), .CPU_IRQ(CPU_IRQ), .BUS_OWN(BUS_OWN), .BUS_ADDR(BUS_ADDR),
  .BUS_WRITE(BUS_WRITE), .IRQ_REQ(IRQ_REQ), .BREAK_HIT(BREAK_HIT));
`default_nettype wire

// >>> testbench/tcd_periph.sv
// peripheral model holding a service request until its units are served
`timescale 1ns/1ps
`default_nettype none
module tcd_periph (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       bus_own,
  input  wire logic       bus_write,
  input  wire logic       load,
  input  wire logic [2:0] chan,
  input  wire logic [3:0] units,
  output logic      [2:0] ch_req
);
  logic [3:0] left_q;
  // one unit served per destination cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      left_q <= 4'h0;
    end else if (load) begin
      left_q <= units;
    end else if (bus_own && bus_write && left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  assign ch_req = (left_q != 4'h0) ? chan : 3'h0; // level request
endmodule // tcd_periph
`default_nettype wire
